// ===== common/mpw_pkg.sv
package mpw_pkg;

    localparam int          NUM_CH         = 8;
    localparam int          MASTER_CH      = 0;
    localparam int          ADDR_W         = 20;

    // register byte addresses
    localparam logic [19:0] ADDR_DATA0     = 20'hf0180;
    localparam logic [19:0] ADDR_DATA_LAST = 20'hf019c;
    localparam logic [19:0] ADDR_CTRL      = 20'hf01a0;
    localparam logic [19:0] ADDR_STAT      = 20'hf01a4;
    localparam logic [19:0] ADDR_MASK      = 20'hf01a8;
    localparam logic [19:0] ADDR_POL       = 20'hf01bc;
    localparam logic [19:0] ADDR_POL_LO    = 20'hf01c0;

    // control register fields
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_OE_LSB    = 8;
    localparam int          CTRL_MODE_LSB  = 16;

    // reset values and writable masks
    localparam logic [15:0] POL_RESET      = 16'h0000;
    localparam logic [15:0] POL_WR_MASK    = 16'h00fe;
    localparam logic [7:0]  MODE_WR_MASK   = 8'hfe;
    localparam logic [15:0] DATA_RESET     = 16'h0000;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// ===== rtl/mpw_top.sv
// Added by the designer: the AXI4-Lite register port.
module mpw_top
    import mpw_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [NUM_CH-1:0]        slave_pwm_pin,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [W-1:0]        channel_data_value [NUM_CH];
    logic [W-1:0]        channel_counter    [NUM_CH];
    logic [NUM_CH-1:0]   busy_ff;
    logic [NUM_CH-1:0]   raw_ff;
    logic [NUM_CH-1:0]   nxt_raw;
    logic [NUM_CH-1:0]   pol_act_ff;
    logic [NUM_CH-1:0]   nxt_pol_act;
    logic [NUM_CH-1:0]   channel_interrupt;
    logic [NUM_CH-1:0]   nxt_irq_ev;
    logic [NUM_CH-1:0]   stat_ff;
    logic [NUM_CH-1:0]   nxt_stat;
    logic [NUM_CH-1:0]   mask_ff;
    logic [NUM_CH-1:0]   channel_output_enable;
    logic [NUM_CH-1:0]   channel_output_mode;
    logic [NUM_CH-1:0]   pin_ff;
    logic [15:0]         output_polarity_reg;
    logic                run_ff;
    logic                irq_ff;
    logic                m_irq;

    logic                aw_held_ff;
    logic                w_held_ff;
    logic [ADDR_W-1:0]   aw_addr_ff;
    logic [31:0]         wdata_ff;
    logic [3:0]          wstrb_ff;
    logic                awready_ff;
    logic                wready_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                arready_ff;
    logic                rvalid_ff;
    logic [31:0]         rdata_ff;
    logic [1:0]          rresp_ff;
    logic                aw_take;
    logic                w_take;
    logic                do_wr;
    logic                nxt_aw_held;
    logic                nxt_w_held;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a[1:0] == 2'h0) &&
                   ((a >= ADDR_DATA0 && a <= ADDR_DATA_LAST) ||
                    a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_MASK ||
                    a == ADDR_POL || a == ADDR_POL_LO);
    endfunction

    function automatic logic [2:0] data_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off      = a - ADDR_DATA0;
        data_idx = off[4:2];
    endfunction

    function automatic logic [15:0] strobe16(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
        strobe16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // axi write channel
    assign aw_take     = s_axi_awvalid & awready_ff;
    assign w_take      = s_axi_wvalid & wready_ff;
    assign do_wr       = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign nxt_aw_held = (aw_held_ff | aw_take) & ~do_wr;
    assign nxt_w_held  = (w_held_ff | w_take) & ~do_wr;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= '0;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end
        else if (ce)
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready_ff <= ~nxt_aw_held;
            wready_ff  <= ~nxt_w_held;
            if (aw_take)
                aw_addr_ff <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addr_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < NUM_CH; k++)
                channel_data_value[k] <= DATA_RESET;
            run_ff                <= 1'b0;
            channel_output_enable <= '0;
            channel_output_mode   <= '0;
            mask_ff               <= '0;
            output_polarity_reg   <= POL_RESET;
        end
        else if (ce && do_wr && addr_hit(aw_addr_ff))
        begin
            if (aw_addr_ff >= ADDR_DATA0 && aw_addr_ff <= ADDR_DATA_LAST)
                channel_data_value[data_idx(aw_addr_ff)] <=
                    strobe16(channel_data_value[data_idx(aw_addr_ff)], wdata_ff, wstrb_ff);
            if (aw_addr_ff == ADDR_CTRL)
            begin
                if (wstrb_ff[0])
                    run_ff <= wdata_ff[CTRL_RUN_BIT];
                if (wstrb_ff[1])
                    channel_output_enable <= wdata_ff[CTRL_OE_LSB +: NUM_CH];
                if (wstrb_ff[2])
                    channel_output_mode <= wdata_ff[CTRL_MODE_LSB +: NUM_CH] & MODE_WR_MASK;
            end
            if (aw_addr_ff == ADDR_MASK && wstrb_ff[0])
                mask_ff <= wdata_ff[NUM_CH-1:0];
            if (aw_addr_ff == ADDR_POL)
                output_polarity_reg <= strobe16(output_polarity_reg, wdata_ff, wstrb_ff)
                                       & POL_WR_MASK;
            if (aw_addr_ff == ADDR_POL_LO && wstrb_ff[0])
                output_polarity_reg <= {8'h00, wdata_ff[7:0]} & POL_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi read channel
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && arready_ff)
            begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rresp_ff   <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                rdata_ff   <= 32'h0;
                if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr >= ADDR_DATA0 &&
                    s_axi_araddr <= ADDR_DATA_LAST)
                    rdata_ff <= {16'h0000, channel_data_value[data_idx(s_axi_araddr)]};
                else if (s_axi_araddr == ADDR_CTRL)
                    rdata_ff <= {8'h00, channel_output_mode, channel_output_enable,
                                 7'h00, run_ff};
                else if (s_axi_araddr == ADDR_STAT)
                    rdata_ff <= {24'h000000, stat_ff};
                else if (s_axi_araddr == ADDR_MASK)
                    rdata_ff <= {24'h000000, mask_ff};
                else if (s_axi_araddr == ADDR_POL)
                    rdata_ff <= {16'h0000, output_polarity_reg};
                else if (s_axi_araddr == ADDR_POL_LO)
                    rdata_ff <= {24'h000000, output_polarity_reg[7:0]};
            end
            else if (rvalid_ff && s_axi_rready)
            begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
            else if (!rvalid_ff)
                arready_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // master and slave counters
    assign m_irq = channel_interrupt[MASTER_CH];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < NUM_CH; k++)
                channel_counter[k] <= '0;
            busy_ff <= '0;
        end
        else if (ce)
        begin
            if (!run_ff || channel_counter[MASTER_CH] == '0)
                channel_counter[MASTER_CH] <= channel_data_value[MASTER_CH];
            else
                channel_counter[MASTER_CH] <= channel_counter[MASTER_CH] - 1'b1;
            for (int k = 1; k < NUM_CH; k++)
            begin
                if (!run_ff)
                begin
                    channel_counter[k] <= '0;
                    busy_ff[k]         <= 1'b0;
                end
                else if (m_irq)
                begin
                    channel_counter[k] <= channel_data_value[k];
                    busy_ff[k]         <= channel_data_value[k] != '0;
                end
                else if (busy_ff[k])
                begin
                    channel_counter[k] <= channel_counter[k] - 1'b1;
                    busy_ff[k]         <= channel_counter[k] != 1;
                end
            end
        end
    end

    // output set/reset and channel events
    always_comb
    begin
        nxt_raw    = '0;
        nxt_irq_ev = '0;
        if (run_ff)
        begin
            nxt_raw                = raw_ff;
            nxt_raw[MASTER_CH]     = raw_ff[MASTER_CH] ^ m_irq;
            nxt_irq_ev[MASTER_CH]  = channel_counter[MASTER_CH] == '0;
            for (int k = 1; k < NUM_CH; k++)
            begin
                if (m_irq)
                begin
                    // still-active output is simply re-set, giving full duty
                    nxt_raw[k]    = channel_data_value[k] != '0;
                    nxt_irq_ev[k] = channel_data_value[k] == '0;
                end
                else if (busy_ff[k] && channel_counter[k] == 1)
                begin
                    nxt_raw[k]    = 1'b0;
                    nxt_irq_ev[k] = 1'b1;
                end
            end
        end
        // polarity latched only when the output changes
        for (int k = 0; k < NUM_CH; k++)
            nxt_pol_act[k] = (nxt_raw[k] != raw_ff[k]) ? output_polarity_reg[k]
                                                        : pol_act_ff[k];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_ff            <= '0;
            pol_act_ff        <= '0;
            channel_interrupt <= '0;
            pin_ff            <= '0;
        end
        else if (ce)
        begin
            raw_ff            <= nxt_raw;
            pol_act_ff        <= nxt_pol_act;
            channel_interrupt <= nxt_irq_ev;
            pin_ff            <= channel_output_enable
                                 & (nxt_raw ^ (channel_output_mode & nxt_pol_act));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky status, set wins over write-one-clear
    always_comb
    begin
        nxt_stat = stat_ff;
        if (do_wr && aw_addr_ff == ADDR_STAT && wstrb_ff[0])
            nxt_stat = nxt_stat & ~wdata_ff[NUM_CH-1:0];
        nxt_stat = nxt_stat | channel_interrupt;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_ff <= '0;
            irq_ff  <= 1'b0;
        end
        else if (ce)
        begin
            stat_ff <= nxt_stat;
            irq_ff  <= |(nxt_stat & mask_ff);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign slave_pwm_pin = pin_ff;
    assign irq           = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    pol_reset_a: assert property ($rose(rst_n) |-> output_polarity_reg == POL_RESET)
        else $error("polarity register not cleared by reset");
    pol_reserved_a: assert property (
        (output_polarity_reg & ~POL_WR_MASK) == 16'h0000)
        else $error("polarity reserved bit set");
    master_reload_a: assert property (ce && run_ff
        && channel_counter[MASTER_CH] == '0
        |=> m_irq && channel_counter[MASTER_CH] == $past(channel_data_value[MASTER_CH]))
        else $error("master did not reload with interrupt");
    pin_stage_a: assert property (ce |=> pin_ff == ($past(channel_output_enable)
        & (raw_ff ^ ($past(channel_output_mode) & pol_act_ff))))
        else $error("pin does not follow enable, mode and polarity");
    pol_defer_a: assert property (ce && nxt_raw == raw_ff |=> $stable(pol_act_ff))
        else $error("polarity changed without output change");

    for (genvar g = 1; g < NUM_CH; g++)
    begin : g_slave_chk
        slave_load_a: assert property (ce && run_ff && m_irq
            |=> channel_counter[g] == $past(channel_data_value[g]))
            else $error("slave did not load on master interrupt");
        slave_active_a: assert property (ce && run_ff && m_irq
            && channel_data_value[g] != '0 |=> raw_ff[g])
            else $error("slave output not active after master interrupt");
        slave_stop_a: assert property (ce && run_ff && busy_ff[g] && !m_irq
            && channel_counter[g] == 1
            |=> !raw_ff[g] && !busy_ff[g] && channel_interrupt[g] && channel_counter[g] == '0)
            else $error("slave did not stop with interrupt at zero");
    end

    full_duty_c: cover property (ce && m_irq && raw_ff[3] && channel_data_value[3] != '0);
    inverted_pin_c: cover property (|(pin_ff & ~raw_ff));
    alias_write_c: cover property (do_wr && aw_addr_ff == ADDR_POL_LO);
    irq_out_c: cover property ($rose(irq_ff));

endmodule

// ===== dv/mpw_load_model.sv
////////////////////////////////////////////////////////////////////////////////
module mpw_load_model
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  pins,
    output logic      [15:0] period_ff,
    output logic      [15:0] high_ff [8]
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] cnt_ff;
    logic [15:0] hcnt_ff [8];
    logic        prev_ff;

    // window runs from one master pin edge to the next
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff    <= 16'h0000;
            prev_ff   <= 1'b0;
            period_ff <= 16'h0000;
            for (int i = 0; i < 8; i++)
            begin
                hcnt_ff[i] <= 16'h0000;
                high_ff[i] <= 16'h0000;
            end
        end
        else
        begin
            prev_ff <= pins[0];
            if (pins[0] != prev_ff)
            begin
                period_ff <= cnt_ff;
                cnt_ff    <= 16'h0001;
            end
            else
                cnt_ff <= cnt_ff + 16'h0001;
            for (int i = 0; i < 8; i++)
            begin
                if (pins[0] != prev_ff)
                begin
                    high_ff[i] <= hcnt_ff[i];
                    hcnt_ff[i] <= {15'h0000, pins[i]};
                end
                else
                    hcnt_ff[i] <= hcnt_ff[i] + {15'h0000, pins[i]};
            end
        end
    end
endmodule

// ===== dv/tb.sv
////////////////////////////////////////////////////////////////////////////////
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mpw_pkg::*;

    logic              clock, rst_n, ce;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, irq;
    logic [7:0]        pins;
    logic [15:0]       prd;
    logic [15:0]       hi [8];
    logic [7:0]        oe, md, pl, pk;
    int                err_total, tests_run, seed, p;
    int                d [8];

    mpw_top dut (.clock(clock), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .slave_pwm_pin(pins), .irq(irq));

    mpw_load_model load (.clock(clock), .rst_n(rst_n), .pins(pins),
        .period_ff(prd), .high_ff(hi));

    always #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // each channel is held until the edge that sees its ready high
    task axi_wr(input logic [19:0] a, input logic [31:0] dt, input logic [3:0] s,
                input logic [1:0] er);
        logic ad, wd, ha, hw, hb;
        ad = 0;
        wd = 0;
        hb = 0;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= dt;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        while (!(ad && wd))
        begin
            @(negedge clock);
            ha = s_axi_awready && !ad;
            hw = s_axi_wready && !wd;
            @(posedge clock);
            if (ha)
            begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (hw)
            begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        while (!hb)
        begin
            @(negedge clock);
            hb = s_axi_bvalid;
            if (hb)
                chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
            @(posedge clock);
        end
        s_axi_bready <= 1'b0;
    endtask

    task axi_rd(input logic [19:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ha, hr;
        ha = 0;
        hr = 0;
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!hr)
        begin
            @(negedge clock);
            if (s_axi_arvalid && s_axi_arready)
                ha = 1;
            hr = s_axi_rvalid;
            if (hr)
            begin
                chk(s_axi_rdata, e, "rdata");
                chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
            end
            @(posedge clock);
            if (ha)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    function automatic int exp_hi(int dv, int pv, logic o, logic m, logic l);
        int a;
        a = (dv < pv) ? dv : pv;
        if (!o)
            return 0;
        return (m && l) ? pv - a : a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6000) @(posedge clock);
        err_total++;
        stop_test();
    end

    initial
    begin
        clock = 0;
        seed = 8;
        err_total = 0;
        tests_run = 0;
        rst_n <= 1'b0;
        ce <= 1'b1;
        s_axi_awaddr <= '0;
        s_axi_araddr <= '0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        axi_rd(ADDR_POL, 32'h0, RESP_OKAY);
        axi_wr(ADDR_POL, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_rd(ADDR_POL, 32'h0000_00fe, RESP_OKAY);
        axi_wr(ADDR_POL_LO, 32'h0000_0055, 4'h1, RESP_OKAY);
        axi_rd(ADDR_POL, 32'h0000_0054, RESP_OKAY);
        axi_wr(20'hf01b0, 32'h1, 4'hf, RESP_SLVERR);
        axi_rd(20'hf01b0, 32'h0, RESP_SLVERR);
        axi_rd(ADDR_POL + 20'h1, 32'h0, RESP_SLVERR);
        for (int ph = 0; ph < 2; ph++)
        begin
            p  = 4 + int'($unsigned($random(seed)) % 9);
            oe = ph ? (8'($random(seed)) | 8'h01) : 8'hff;
            md = ph ? (8'($random(seed)) & MODE_WR_MASK) : MODE_WR_MASK;
            pl = ph ? (8'($random(seed)) & 8'hfe) : 8'h00;
            axi_wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
            axi_wr(ADDR_DATA0, 32'(p - 1), 4'h3, RESP_OKAY);
            for (int i = 1; i < 8; i++)
            begin
                // first pass holds the corners: zero, short and beyond the period
                d[i] = ph ? 1 + int'($unsigned($random(seed)) % (p - 1))
                     : (i == 1) ? 1 : (i == 2) ? 0 : (i == 3) ? p + 2
                     : int'($unsigned($random(seed)) % (p + 3));
                axi_wr(ADDR_DATA0 + 20'(4 * i), 32'(d[i]), 4'h3, RESP_OKAY);
            end
            axi_wr(ADDR_POL_LO, {24'h0, pl}, 4'h1, RESP_OKAY);
            axi_wr(ADDR_CTRL, {8'h00, md, oe, 8'h01}, 4'hf, RESP_OKAY);
            repeat (5 * p + 4) @(posedge clock);
            @(negedge clock);
            chk(32'(prd), 32'(p), "period");
            for (int i = 1; i < 8; i++)
                chk(32'(hi[i]), 32'(exp_hi(d[i], p, oe[i], md[i], pl[i])), "duty");
            // freeze longer than the longest period: the master pin must not toggle
            @(posedge clock);
            ce <= 1'b0;
            @(negedge clock);
            pk = pins;
            repeat (13) @(negedge clock);
            chk({24'h0, pins}, {24'h0, pk}, "ce freeze");
            @(posedge clock);
            ce <= 1'b1;
        end
        axi_rd(ADDR_STAT, 32'h0000_00ff, RESP_OKAY);
        chk({31'h0, irq}, 32'h0, "irq masked");
        axi_wr(ADDR_MASK, 32'h0000_0002, 4'h1, RESP_OKAY);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({31'h0, irq}, 32'h1, "irq raised");
        axi_wr(ADDR_CTRL, {8'h00, md, oe, 8'h00}, 4'hf, RESP_OKAY);
        axi_wr(ADDR_STAT, 32'h0000_00ff, 4'h1, RESP_OKAY);
        axi_rd(ADDR_STAT, 32'h0, RESP_OKAY);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // stopped outputs rest at their inactive level, high when active-low
        chk({24'h0, pins}, {24'h0, oe & md & pl}, "pins stopped");
        stop_test();
    end
endmodule
